// >>> core/cwb_pkg.sv
// cwb_pkg: shared constants and carrier types for the bridge steering block
// assumes one 100 MHz system clock; dead-band clock arrives as an enable pulse
package cwb_pkg;

   // operating mode codes
   typedef enum logic [2:0] {
      CWB_MODE_ASTEER = 3'h0,
      CWB_MODE_SSTEER = 3'h1,
      CWB_MODE_FWD    = 3'h2,
      CWB_MODE_REV    = 3'h3
   } cwb_mode_t;

   // data input select codes
   localparam logic [2:0] CWB_SEL_PIN = 3'h0;
   localparam logic [2:0] CWB_SEL_CC1 = 3'h1;
   localparam logic [2:0] CWB_SEL_CC2 = 3'h2;
   localparam logic [2:0] CWB_SEL_PW3 = 3'h3;
   localparam logic [2:0] CWB_SEL_PW4 = 3'h4;
   localparam logic [2:0] CWB_SEL_CP1 = 3'h5;
   localparam logic [2:0] CWB_SEL_CP2 = 3'h6;
   localparam logic [2:0] CWB_SEL_MOD = 3'h7;

   // field widths and positions
   localparam int unsigned CWB_DB_W   = 6;
   localparam int unsigned CWB_NOUT   = 4;
   localparam int unsigned CWB_IDX_A  = 0;
   localparam int unsigned CWB_IDX_B  = 1;
   localparam int unsigned CWB_IDX_C  = 2;
   localparam int unsigned CWB_IDX_D  = 3;
   localparam int unsigned CWB_SYNC_STAGES = 2;

   // reset values
   localparam logic [3:0]          CWB_OUT_RST = 4'h0;
   localparam logic [CWB_DB_W-1:0] CWB_DB_RST  = 6'h00;

   // eight raw data sources, index equals the select code
   typedef struct packed {
      logic signal_modulator_output;
      logic comparator2_output;
      logic comparator1_output;
      logic pulse_width4_output;
      logic pulse_width3_output;
      logic capture_compare2_output;
      logic capture_compare1_output;
      logic input_pin_selector;
   } cwb_src_t;

   // per-output configuration, bit index A=0 .. D=3
   typedef struct packed {
      logic [3:0] steer_enable_y;
      logic [3:0] override_level_y;
      logic [3:0] output_polarity_y;
   } cwb_outcfg_t;

endpackage : cwb_pkg

// >>> core/cwb_sync.sv
// cwb_sync: two-flop synchroniser for one asynchronous level
// assumes the destination clock is i_clk_sys; no logic reads the first flop
`timescale 1ns/100ps
module cwb_sync (
   input  wire logic i_clk_sys,
   input  wire logic i_rst_n,
   input  wire logic i_async,
   output logic      o_sync
);
   import cwb_pkg::*;

   logic [CWB_SYNC_STAGES-1:0] stage_q;
   logic [CWB_SYNC_STAGES-1:0] stage_d;

   // shift in the raw level
   always_comb begin
      stage_d = {stage_q[CWB_SYNC_STAGES-2:0], i_async};
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stage_q <= '0;
      end else begin
         stage_q <= stage_d;
      end
   end

   assign o_sync = stage_q[CWB_SYNC_STAGES-1];

endmodule : cwb_sync

// >>> core/cwb_bridge.sv
// cwb_bridge: full-bridge and steering output logic of the waveform generator
// assumes all controls come from software on i_clk_sys; data sources are
// asynchronous; the dead-band clock is an enable pulse from a divider outside
`timescale 1ns/100ps
// Contract
// (RQ1) forward full bridge: A active, B and C inactive, D follows data
// (RQ2) reverse full bridge: C active, A and D inactive, B follows data
// (RQ3) full bridge dead band only on direction change, only on modulated output
// (RQ4) lowest mode bit may toggle while enabled to swap direction
// (RQ5) new direction applies at next rising data edge, not at write
// (RQ6) on swap: A/C exchange, old modulated output off, new one after dead band
// (RQ7) rising data edge gives rising event on modulated output before polarity
// (RQ8) each output has its own polarity selection
// (RQ9) steering routes data to any outputs, fixed levels elsewhere, no dead band
// (RQ10) steer bit clear holds override level; set passes data
// (RQ11) polarity applies only to steered outputs; overrides unaffected
// (RQ12) shutdown in steering overrides only steered outputs
// (RQ13) synchronous steering defers steer changes to next rising data edge
// (RQ14) only steer bits synchronised; override writes act immediately
// (RQ15) asynchronous steering applies steer writes at once, may truncate pulse
// (RQ16) one clock-select bit picks system clock or internal oscillator
// (RQ17) oscillator selection keeps it running in sleep; system clock stops
// (RQ18) 3-bit input select chooses among eight data sources
// (RQ19) dead band counts clock periods up to 6-bit value; zero means none
// (RQ20) rising count for forward-to-reverse on B, falling for reverse-to-forward on D
// (RQ21) polarity set is active-high, clear active-low; overrides untouched
// (RQ22) software changes mode only while disabled, except direction toggle
// (RQ23) selected data input synchronised before edge detection
module cwb_bridge (
   input  wire logic                         i_clk_sys,
   input  wire logic                         i_rstn,
   input  wire logic                         i_enable,
   input  wire logic                         i_sleep,
   input  wire logic                         i_clk_select,
   input  wire logic                         i_sysclk_tick,
   input  wire logic                         i_hfosc_tick,
   input  wire cwb_pkg::cwb_mode_t           i_mode,
   input  wire logic [2:0]                   i_data_input_select,
   input  wire cwb_pkg::cwb_src_t            i_sources,
   input  wire cwb_pkg::cwb_outcfg_t         i_outcfg,
   input  wire logic [cwb_pkg::CWB_DB_W-1:0] i_rising_dead_band_count,
   input  wire logic [cwb_pkg::CWB_DB_W-1:0] i_falling_dead_band_count,
   input  wire logic                         i_shutdown,
   input  wire logic                         i_shutdown_level_ac,
   input  wire logic                         i_shutdown_level_bd,
   output logic                              o_bridge_out_a,
   output logic                              o_bridge_out_b,
   output logic                              o_bridge_out_c,
   output logic                              o_bridge_out_d,
   output logic                              o_hfosc_request,
   output logic                              o_reverse,
   output logic                              o_dead_band_busy
);
   import cwb_pkg::*;

   logic                rst_meta_q;
   logic                rst_sync_q;
   logic                rst_n;
   logic                data_s;
   logic                data_prev_q;
   logic                data_prev_d;
   logic                data_rise;
   logic                db_tick;
   logic [7:0]          src_s;
   logic                fb_mode;
   logic                rev_q;
   logic                rev_d;
   logic [3:0]          steer_q;
   logic [3:0]          steer_d;
   logic [CWB_DB_W-1:0] db_cnt_q;
   logic [CWB_DB_W-1:0] db_cnt_d;
   logic [CWB_DB_W-1:0] db_lim_q;
   logic [CWB_DB_W-1:0] db_lim_d;
   logic                db_run_q;
   logic                db_run_d;
   logic [3:0]          out_q;
   logic [3:0]          out_d;
   logic                hfreq_q;
   logic                hfreq_d;
   logic [3:0]          pre_pol;
   logic [3:0]          shut_lvl;

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   // every raw source gets its own synchroniser; a mux ahead of the flops
   // would feed select-change glitches straight into the first stage
   for (genvar g = 0; g < $bits(cwb_src_t); g++) begin : g_src_sync
      cwb_sync u_data_sync (
         .i_clk_sys (i_clk_sys),
         .i_rst_n   (rst_n),
         .i_async   (i_sources[g]),
         .o_sync    (src_s[g])
      ); // RQ23
   end

   // pick the data source from the synchronised levels
   always_comb begin
      data_s = 1'b0;
      unique case (i_data_input_select)
         CWB_SEL_PIN: data_s = src_s[0]; // RQ18
         CWB_SEL_CC1: data_s = src_s[1];
         CWB_SEL_CC2: data_s = src_s[2];
         CWB_SEL_PW3: data_s = src_s[3];
         CWB_SEL_PW4: data_s = src_s[4];
         CWB_SEL_CP1: data_s = src_s[5];
         CWB_SEL_CP2: data_s = src_s[6];
         CWB_SEL_MOD: data_s = src_s[7]; // RQ18
      endcase
   end

   // dead-band clock source; system clock gives no ticks while asleep
   always_comb begin
      if (i_clk_select) begin // RQ16
         db_tick = i_hfosc_tick;
      end else begin
         db_tick = i_sysclk_tick & ~i_sleep; // RQ17
      end
   end

   // oscillator stays requested in sleep while it times the dead band
   always_comb begin
      hfreq_d = i_enable & i_clk_select; // RQ17
   end

   assign fb_mode   = (i_mode == CWB_MODE_FWD) || (i_mode == CWB_MODE_REV);
   assign data_rise = data_s & ~data_prev_q;
   assign data_prev_d = data_s;

   // direction and steering latches, updated on the data edge except when disabled or in asynchronous steering
   always_comb begin
      rev_d   = rev_q;
      steer_d = steer_q;
      if (!i_enable) begin
         // disabled: pick up settings directly, mode changes are legal here
         rev_d   = (i_mode == CWB_MODE_REV); // RQ22
         steer_d = i_outcfg.steer_enable_y;
      end else if (fb_mode) begin
         if (data_rise) begin
            rev_d = i_mode[0]; // RQ4 RQ5
         end
      end else if (i_mode == CWB_MODE_SSTEER) begin
         if (data_rise) begin
            steer_d = i_outcfg.steer_enable_y; // RQ13 RQ14
         end
      end else begin
         steer_d = i_outcfg.steer_enable_y; // RQ15
      end
   end

   // dead-band counter: starts on a direction swap, counts dead-band ticks
   always_comb begin
      db_cnt_d = db_cnt_q;
      db_lim_d = db_lim_q;
      db_run_d = db_run_q;
      if (!i_enable || !fb_mode) begin
         db_run_d = 1'b0; // RQ9
         db_cnt_d = CWB_DB_RST;
      end else if (data_rise && (i_mode[0] != rev_q)) begin
         // rising count going to reverse, falling count going to forward
         db_lim_d = i_mode[0] ? i_rising_dead_band_count
                              : i_falling_dead_band_count; // RQ20
         db_cnt_d = CWB_DB_RST;
         db_run_d = (db_lim_d != CWB_DB_RST); // RQ19
      end else if (db_run_q && db_tick) begin
         if (db_cnt_q + 6'h01 >= db_lim_q) begin
            db_run_d = 1'b0; // RQ19
            db_cnt_d = CWB_DB_RST;
         end else begin
            db_cnt_d = db_cnt_q + 6'h01;
         end
      end
   end

   // active-high levels before polarity
   always_comb begin
      pre_pol = 4'h0;
      if (fb_mode) begin
         // static legs switch with the direction, no dead band on them
         pre_pol[CWB_IDX_A] = ~rev_d; // RQ1 RQ3 RQ6
         pre_pol[CWB_IDX_C] = rev_d;  // RQ2 RQ3 RQ6
         // modulated leg held off while the swap dead band runs
         pre_pol[CWB_IDX_D] = ~rev_d & data_s & ~db_run_d; // RQ1 RQ6 RQ7
         pre_pol[CWB_IDX_B] = rev_d & data_s & ~db_run_d;  // RQ2 RQ6 RQ7
      end else begin
         pre_pol = {4{data_s}} & steer_d; // RQ9 RQ10
      end
   end

   assign shut_lvl = {i_shutdown_level_bd, i_shutdown_level_ac,
                      i_shutdown_level_bd, i_shutdown_level_ac};

   // final output level per leg
   always_comb begin
      for (int i = 0; i < CWB_NOUT; i++) begin
         if (!i_enable) begin
            out_d[i] = i_outcfg.override_level_y[i];
         end else if (!fb_mode && !steer_d[i]) begin
            // unsteered: override level, no polarity, no shutdown
            out_d[i] = i_outcfg.override_level_y[i]; // RQ10 RQ11 RQ12 RQ14
         end else if (i_shutdown) begin
            out_d[i] = shut_lvl[i]; // RQ12 RQ21
         end else begin
            // polarity set is active-high, clear inverts
            out_d[i] = i_outcfg.output_polarity_y[i] ? pre_pol[i]
                                                     : ~pre_pol[i]; // RQ8 RQ11 RQ21
         end
      end
   end

   // data edge history; reset low so a low idle source gives no false edge
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         data_prev_q <= 1'b0;
      end else begin
         data_prev_q <= data_prev_d;
      end
   end

   // direction and steering latches
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rev_q   <= 1'b0;
         steer_q <= 4'h0;
      end else begin
         rev_q   <= rev_d;
         steer_q <= steer_d;
      end
   end

   // dead-band counter state
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         db_cnt_q <= CWB_DB_RST;
         db_lim_q <= CWB_DB_RST;
         db_run_q <= 1'b0;
      end else begin
         db_cnt_q <= db_cnt_d;
         db_lim_q <= db_lim_d;
         db_run_q <= db_run_d;
      end
   end

   // output legs
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         out_q <= CWB_OUT_RST;
      end else begin
         out_q <= out_d;
      end
   end

   // oscillator request
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hfreq_q <= 1'b0;
      end else begin
         hfreq_q <= hfreq_d;
      end
   end

   // all outputs straight from flops
   assign o_bridge_out_a   = out_q[CWB_IDX_A];
   assign o_bridge_out_b   = out_q[CWB_IDX_B];
   assign o_bridge_out_c   = out_q[CWB_IDX_C];
   assign o_bridge_out_d   = out_q[CWB_IDX_D];
   assign o_hfosc_request  = hfreq_q;
   assign o_reverse        = rev_q;
   assign o_dead_band_busy = db_run_q;

endmodule : cwb_bridge

// >>> sim/cwb_bridge_sva.sv
// cwb_bridge_sva: port checks on the bridge steering block
// assumes bind into cwb_bridge; checks wait until the internal reset settles
`timescale 1ns/100ps
module cwb_bridge_sva
   import cwb_pkg::*;
(
   input wire logic                 i_clk_sys,
   input wire logic                 i_rstn,
   input wire logic                 i_enable,
   input wire logic                 i_clk_select,
   input wire cwb_pkg::cwb_mode_t   i_mode,
   input wire logic [2:0]           i_data_input_select,
   input wire cwb_pkg::cwb_src_t    i_sources,
   input wire cwb_pkg::cwb_outcfg_t i_outcfg,
   input wire logic [5:0]           i_rising_dead_band_count,
   input wire logic [5:0]           i_falling_dead_band_count,
   input wire logic                 i_shutdown,
   input wire logic                 i_shutdown_level_ac,
   input wire logic                 i_shutdown_level_bd,
   input wire logic                 o_bridge_out_a,
   input wire logic                 o_bridge_out_b,
   input wire logic                 o_bridge_out_c,
   input wire logic                 o_bridge_out_d,
   input wire logic                 o_hfosc_request,
   input wire logic                 o_reverse,
   input wire logic                 o_dead_band_busy
);
   logic [2:0] rdy_q, rdy_d;
   logic [7:0] hist_q, hist_d;
   logic [3:0] outs, lvl, stv, ovr, pol;
   logic       rdy, rose_seen;
   // settle counter; raw source history, since the sync delay is not exact
   always_comb begin
      rdy_d  = rdy_q + {2'h0, rdy_q != 3'h4};
      hist_d = {hist_q[6:0], i_sources[i_data_input_select]};
   end
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         rdy_q  <= 3'h0;
         hist_q <= 8'h00;
      end else begin
         rdy_q  <= rdy_d;
         hist_q <= hist_d;
      end
   end
   assign rdy       = rdy_q == 3'h4;
   assign rose_seen = |(hist_q[6:0] & ~hist_q[7:1]);
   assign outs      = {o_bridge_out_d, o_bridge_out_c, o_bridge_out_b, o_bridge_out_a};
   assign lvl       = {2{i_shutdown_level_bd, i_shutdown_level_ac}};
   assign {stv, ovr, pol} = i_outcfg;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   // steady enabled configuration for three cycles
   sequence s_held(cond);
      (rdy && i_enable && $stable(i_outcfg) && cond) [*3];
   endsequence
   a_osc_request : assert property (
      rdy |=> o_hfosc_request == $past(i_enable && i_clk_select)) else $error("bad osc request");
   a_fwd_static : assert property (
      s_held(!i_shutdown && i_mode == CWB_MODE_FWD && !o_reverse) |-> o_bridge_out_a == pol[0]
      && o_bridge_out_b != pol[1] && o_bridge_out_c != pol[2]) else $error("forward legs wrong");
   a_rev_static : assert property (
      s_held(!i_shutdown && i_mode == CWB_MODE_REV && o_reverse) |-> o_bridge_out_c == pol[2]
      && o_bridge_out_a != pol[0] && o_bridge_out_d != pol[3]) else $error("reverse legs wrong");
   a_band_quiet : assert property (
      rdy && o_dead_band_busy && i_enable && !i_shutdown && !$past(i_shutdown)
      && $stable(i_outcfg) |->
      (o_reverse ? o_bridge_out_b != pol[1] : o_bridge_out_d != pol[3])) else $error("leg early");
   a_band_count : assert property (
      rdy && $rose(o_dead_band_busy) |-> (o_reverse ? $past(i_rising_dead_band_count)
      : $past(i_falling_dead_band_count)) != 6'h00) else $error("dead band with zero count");
   a_swap_edge : assert property (
      rdy && i_enable && $past(i_enable) && $past(i_enable, 2) && $changed(o_reverse)
      |-> rose_seen) else $error("direction swap without data rise");
   a_steer_fixed : assert property (
      s_held(!i_shutdown && i_mode == CWB_MODE_ASTEER) |-> ((outs ^ ovr) & ~stv) == 4'h0)
      else $error("unsteered leg wrong");
   a_steer_shut : assert property (
      s_held(i_shutdown && i_mode == CWB_MODE_ASTEER) |-> outs == ((stv & lvl) | (~stv & ovr)))
      else $error("shutdown levels wrong");
   c_band : cover property (rdy && $rose(o_dead_band_busy));
   c_swap : cover property (rdy && $changed(o_reverse));
   c_shut : cover property (rdy && i_shutdown && i_mode == CWB_MODE_ASTEER);
endmodule : cwb_bridge_sva
bind cwb_bridge cwb_bridge_sva i_sva (.*);

// >>> sim/cwb_bridge_drv.sv
// cwb_bridge_drv: power switch model on the four bridge legs
// assumes legs A/B form one half bridge and C/D the other
`timescale 1ns/100ps
module cwb_bridge_drv (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rstn,
   input  wire logic       i_arm,
   input  wire logic [3:0] i_leg,
   input  wire logic [3:0] i_pol,
   output logic [7:0]      o_shoot_count
);
   logic [3:0] on;
   // a switch conducts while its leg sits at the active level
   assign on = ~(i_leg ^ i_pol);
   // both switches of one half bridge on together shorts the supply
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_shoot_count <= 8'h00;
      end else if (i_arm && ((on[0] && on[1]) || (on[2] && on[3]))) begin
         o_shoot_count <= o_shoot_count + 8'h01;
      end
   end
endmodule : cwb_bridge_drv

// >>> sim/test_cwb_bridge.sv
// test_cwb_bridge: directed bench for full bridge and steering paths
// assumes cwb_bridge, cwb_bridge_drv and the bound checker are compiled
`timescale 1ns/100ps
module test_cwb_bridge;
   import cwb_pkg::*;
   logic        clk, rstn, en, sleep, csel, tick, stick, sd, lac, lbd, arm, hreq, rev, busy;
   logic [3:0]  outs;
   logic [7:0]  srcv, shoot;
   logic [11:0] cfg;
   logic [5:0]  dbr, dbf;
   logic [2:0]  isel;
   logic [1:0]  tdiv;
   cwb_mode_t   mode;
   int          fail_count, cmp_count;
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
   $display("Error at %0t got %h expected %h", $time, got, exp); end end
   cwb_bridge i_dut (
      .i_clk_sys(clk), .i_rstn(rstn), .i_enable(en), .i_sleep(sleep), .i_clk_select(csel),
      .i_sysclk_tick(stick), .i_hfosc_tick(tick), .i_mode(mode), .i_data_input_select(isel),
      .i_sources(srcv), .i_outcfg(cfg), .i_rising_dead_band_count(dbr),
      .i_falling_dead_band_count(dbf), .i_shutdown(sd), .i_shutdown_level_ac(lac),
      .i_shutdown_level_bd(lbd), .o_bridge_out_a(outs[0]), .o_bridge_out_b(outs[1]),
      .o_bridge_out_c(outs[2]), .o_bridge_out_d(outs[3]), .o_hfosc_request(hreq),
      .o_reverse(rev), .o_dead_band_busy(busy));
   cwb_bridge_drv i_drv (.i_clk_sys(clk), .i_rstn(rstn), .i_arm(arm), .i_leg(outs),
      .i_pol(cfg[3:0]), .o_shoot_count(shoot));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // dead-band ticks: oscillator every fourth cycle, system clock every second,
   // so a wrong clock choice shows up as a wrong dead-band length
   initial begin
      tdiv = 2'h0;
      tick = 1'b0;
      stick = 1'b0;
      forever begin
         @(posedge clk);
         #1;
         tdiv = tdiv + 2'h1;
         tick = (tdiv == 2'h0);
         stick = ~tdiv[0];
      end
   end
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   // mode and configuration only move while the generator is off
   task run(input cwb_mode_t m, input logic [11:0] c);
      en = 1'b0;
      step(2);
      mode = m;
      cfg = c;
      step(2);
      en = 1'b1;
      step(6);
   endtask : run
   task put(input logic v, input int n);
      srcv[isel] = v;
      step(n);
   endtask : put
   task print_verdict();
      $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   initial begin
      {rstn, en, sleep, csel, sd, lac, lbd, arm, srcv, dbr, dbf, isel, cfg} = '0;
      mode = CWB_MODE_ASTEER;
      fail_count = 0;
      cmp_count = 0;
      step(12);
      rstn = 1'b1;
      step(4);
      // forward bridge, every data source in turn
      dbr = 6'h03;
      csel = 1'b1;
      run(CWB_MODE_FWD, 12'h00f);
      arm = 1'b1;
      for (int i = 0; i < 8; i++) begin
         isel = 3'(i);
         put(1'b0, 8);
         `CHK(outs, 4'h1)
         put(1'b1, 8);
         `CHK(outs, 4'h9)
      end
      // swap to reverse waits for a data rise, then the dead band
      put(1'b0, 8);
      mode = CWB_MODE_REV;
      step(8);
      `CHK(outs, 4'h1)
      put(1'b1, 6);
      `CHK({busy, rev, outs}, 6'h34)
      step(20);
      `CHK({busy, outs}, 5'h06)
      put(1'b0, 8);
      mode = CWB_MODE_FWD;
      put(1'b1, 8);
      `CHK({busy, rev, outs}, 6'h09)
      `CHK(shoot, 8'h00)
      arm = 1'b0;
      cfg = 12'h005;
      step(4);
      `CHK(outs, 4'h3)
      // asynchronous steering: A and C steered, B and D held high
      run(CWB_MODE_ASTEER, 12'h5af);
      `CHK(outs, 4'hf)
      put(1'b0, 8);
      `CHK(outs, 4'ha)
      cfg = 12'h5a0;
      step(4);
      `CHK(outs, 4'hf)
      cfg = 12'h0a0;
      step(3);
      `CHK(outs, 4'ha)
      cfg = 12'h3a0;
      {sd, lac, lbd} = 3'b110;
      step(6);
      `CHK(outs, 4'h9)
      sd = 1'b0;
      // synchronous steering holds steer changes until a data rise
      run(CWB_MODE_SSTEER, 12'h0ff);
      cfg = 12'hfff;
      step(8);
      `CHK(outs, 4'hf)
      cfg = 12'hf0f;
      step(3);
      `CHK(outs, 4'h0)
      put(1'b1, 8);
      `CHK(outs, 4'hf)
      sleep = 1'b1;
      step(3);
      `CHK(hreq, 1'b1)
      csel = 1'b0;
      step(3);
      `CHK(hreq, 1'b0)
      // reverse to forward on system ticks: falling count on D, frozen in sleep
      dbf = 6'h02;
      run(CWB_MODE_REV, 12'h00f);
      `CHK({rev, outs}, 5'h16)
      put(1'b0, 8);
      mode = CWB_MODE_FWD;
      put(1'b1, 20);
      `CHK({busy, rev, outs}, 6'h21)
      sleep = 1'b0;
      step(4);
      `CHK({busy, outs}, 5'h09)
      print_verdict();
   end
   // watchdog: the directed run needs well under 2000 cycles
   initial begin
      #50us;
      fail_count++;
      print_verdict();
   end
endmodule : test_cwb_bridge
